// *** design/eth_mac_regs_pkg.sv ***
// Purpose: Constants and carrier types for the MAC register block
// Assumes: 32-bit register port, byte addresses on aligned words
// Notes:   Offsets are byte addresses of 32-bit words
package eth_mac_regs_pkg;

   // ************************************************
   // Register offsets
   // ************************************************
   localparam logic [7:0] OFF_IRQ_STATUS   = 8'h00;
   localparam logic [7:0] OFF_NET_STATUS   = 8'h04;
   localparam logic [7:0] OFF_IRQ_ENABLE   = 8'h08;
   localparam logic [7:0] OFF_IRQ_DISABLE  = 8'h0c;
   localparam logic [7:0] OFF_IRQ_MASK     = 8'h10;
   localparam logic [7:0] OFF_PHY_MAN      = 8'h14;
   localparam logic [7:0] OFF_HASH_HIGH    = 8'h18;
   localparam logic [7:0] OFF_HASH_LOW     = 8'h1c;
   localparam logic [7:0] OFF_UNICAST_BASE = 8'h20;
   localparam int         UNICAST_COUNT    = 4;

   // ************************************************
   // Field positions and reset values
   // ************************************************
   localparam int          IRQ_SOURCES     = 12;
   localparam int          IRQ_DONE_BIT    = 0;
   localparam int          IRQ_LINK_BIT    = 9;
   localparam logic        LINK_IRQ_FITTED = 1'b1;
   localparam int          NET_IDLE_BIT    = 2;
   localparam int          MAN_OP_HI       = 29;
   localparam int          MAN_OP_LO       = 28;
   localparam int          MAN_CODE_HI     = 17;
   localparam int          MAN_CODE_LO     = 16;
   localparam logic [1:0]  MAN_OP_READ     = 2'h2;
   localparam logic [15:0] MASK_RESET      = 16'hffff;
   localparam logic [31:0] ZERO_RESET      = 32'h0;

   // ************************************************
   // Management frame timing, in link clock edges
   // ************************************************
   localparam logic [5:0]  FRAME_BITS      = 6'd32;
   localparam logic [5:0]  READ_DRIVE_BITS = 6'd14;

   // ************************************************
   // Carrier types
   // ************************************************
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic mdio_out;
      logic mdio_oe;
      logic mdc_pin;
   } mdio_io_t;

endpackage : eth_mac_regs_pkg

// *** design/eth_mac_regs.sv ***
// Purpose: MAC interrupt mask, PHY management shifter and address filter registers
// Assumes: Management clock arrives as a pin and is sampled by clk
// Notes:   Interrupt events from the rest of the MAC arrive as one-cycle pulses
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns

// Summary of operation
// - Enable register is write-only; a one clears that source's mask bit, bits 0-11.
// - Disable register is write-only; a one sets that source's mask bit.
// - Mask register is read-only, set bit means masked, resets to 0xffff.
// - Source order: done, rx stored, no buffer, overrun, underrun, retry, ... bus error.
// - Link-change source is an optional fitted feature on bit 9.
// - A management register write loads the shifter and starts the frame.
// - Each shift drives the data line from MSB and samples it into LSB.
// - End of shifting raises the done event and sets the idle indication.
// - Reading the management register returns the shifter's present contents, with bits 17:16 taken from the written code.
// - Operation field 29:28 is 10 for read, 01 for write.
// - Turnaround code 17:16 is written as 10 and reads back as written.
// - Data field 15:0 carries write data or the read result.
// - Hash filter is two read/write words, high 63:32 and low 31:0.
// - Unicast high registers hold address bits 47:32 low, upper half reserved.
// - Unicast low registers hold address bits 31:0.
// - Hash and unicast registers are read/write and reset to zero.
// - Done status sets on completion and clears when status is read.
module eth_mac_regs
   import eth_mac_regs_pkg::*;
(
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        reset,
   // Register port
   input  wire eth_mac_regs_pkg::reg_req_t  req,
   output logic [31:0]                      rdata,
   // Interrupt events and output
   input  wire logic [11:0]                 irq_events,
   input  wire logic                        link_pin,
   output logic                             mac_irq,
   // Management link
   input  wire logic                        mdc,
   input  wire logic                        mdio_in,
   output eth_mac_regs_pkg::mdio_io_t       mdio
);
   import eth_mac_regs_pkg::*;

   // ************************************************
   // Declarations
   // ************************************************
   logic [15:0] mask;
   logic [11:0] status;
   logic [11:0] next_status;
   logic [11:0] events;
   logic [31:0] shift;
   logic [1:0]  code;
   logic        busy;
   logic        idle;
   logic        read_op;
   logic [5:0]  count;
   logic        done_pulse;
   logic        mdio_out_q;
   logic [31:0] hash_high;
   logic [31:0] hash_low;
   logic [15:0] sa_high [UNICAST_COUNT];
   logic [31:0] sa_low  [UNICAST_COUNT];
   logic [2:0]  mdc_sync;
   logic [1:0]  mdio_sync;
   logic [2:0]  link_sync;
   logic [2:0]  link_ready;
   logic        mdc_rise;
   logic        link_change;
   logic        rd_hit_status;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_SHIFT = 2'b10
   } man_state_t;
   man_state_t man_state;

   // ************************************************
   // Pin synchronisers
   // ************************************************
   // Two flops before use; the third only feeds edge detection
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mdc_sync   <= 3'h0;
         mdio_sync  <= 2'h0;
         link_sync  <= 3'h0;
         link_ready <= 3'h0;
      end else begin
         mdc_sync   <= {mdc_sync[1:0], mdc};
         mdio_sync  <= {mdio_sync[0], mdio_in};
         link_sync  <= {link_sync[1:0], link_pin};
         link_ready <= {link_ready[1:0], 1'b1};
      end
   end

   assign mdc_rise    = mdc_sync[1] & ~mdc_sync[2];
   // Synchroniser filling after reset is not a link change
   assign link_change = LINK_IRQ_FITTED & link_ready[2] & (link_sync[1] ^ link_sync[2]);

   // ************************************************
   // Interrupt mask
   // ************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mask <= MASK_RESET;
      end else if (req.wr && req.addr == OFF_IRQ_ENABLE) begin
         mask[11:0] <= mask[11:0] & ~req.wdata[11:0];
      end else if (req.wr && req.addr == OFF_IRQ_DISABLE) begin
         mask[11:0] <= mask[11:0] | req.wdata[11:0];
      end
   end

   // ************************************************
   // Interrupt status
   // ************************************************
   assign rd_hit_status = req.rd && req.addr == OFF_IRQ_STATUS;

   always_comb begin
      events               = irq_events;
      events[IRQ_DONE_BIT] = done_pulse;
      events[IRQ_LINK_BIT] = link_change;
      // New events win over the clearing read
      next_status          = (rd_hit_status ? 12'h0 : status) | events;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status <= 12'h0;
      end else begin
         status <= next_status;
      end
   end

   assign mac_irq = |(status & ~mask[11:0]);

   // ************************************************
   // Management shifter
   // ************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         man_state  <= ST_IDLE;
         shift      <= ZERO_RESET;
         code       <= 2'h0;
         count      <= 6'h0;
         read_op    <= 1'b0;
         busy       <= 1'b0;
         done_pulse <= 1'b0;
         mdio_out_q <= 1'b0;
      end else begin
         done_pulse <= 1'b0;
         if (req.wr && req.addr == OFF_PHY_MAN) begin
            // A write restarts the frame even mid-shift
            man_state     <= ST_SHIFT;
            shift         <= req.wdata;
            code          <= req.wdata[MAN_CODE_HI:MAN_CODE_LO];
            read_op       <= req.wdata[MAN_OP_HI:MAN_OP_LO] == MAN_OP_READ;
            count         <= 6'h0;
            busy          <= 1'b1;
            mdio_out_q    <= req.wdata[31];
         end else begin
            unique case (man_state)
               ST_IDLE: begin
                  busy <= 1'b0;
               end
               ST_SHIFT: begin
                  if (mdc_rise) begin
                     shift         <= {shift[30:0], mdio_sync[1]};
                     mdio_out_q    <= shift[30];
                     count         <= count + 6'd1;
                     if (count == FRAME_BITS - 6'd1) begin
                        man_state  <= ST_IDLE;
                        busy       <= 1'b0;
                        done_pulse <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   assign idle = ~busy;

   // Reads release the line after opcode, address and register fields
   always_comb begin
      mdio.mdio_out = mdio_out_q;
      mdio.mdio_oe  = busy && !(read_op && count >= READ_DRIVE_BITS);
      mdio.mdc_pin  = mdc_sync[1];
   end

   // ************************************************
   // Address filter registers
   // ************************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hash_high <= ZERO_RESET;
         hash_low  <= ZERO_RESET;
      end else if (req.wr && req.addr == OFF_HASH_HIGH) begin
         hash_high <= req.wdata;
      end else if (req.wr && req.addr == OFF_HASH_LOW) begin
         hash_low  <= req.wdata;
      end
   end

   for (genvar i = 0; i < UNICAST_COUNT; i++) begin : g_unicast
      localparam logic [7:0] HI_OFF = OFF_UNICAST_BASE + 8'(8 * i);
      localparam logic [7:0] LO_OFF = OFF_UNICAST_BASE + 8'(8 * i + 4);
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            sa_high[i] <= 16'h0;
            sa_low[i]  <= ZERO_RESET;
         end else if (req.wr && req.addr == HI_OFF) begin
            sa_high[i] <= req.wdata[15:0];
         end else if (req.wr && req.addr == LO_OFF) begin
            sa_low[i]  <= req.wdata;
         end
      end
   end

   // ************************************************
   // Read data
   // ************************************************
   // Unmapped and write-only words read as zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata <= ZERO_RESET;
      end else if (req.rd) begin
         rdata <= ZERO_RESET;
         unique case (req.addr)
            OFF_IRQ_STATUS:  rdata <= {20'h0, status};
            OFF_NET_STATUS:  rdata <= 32'(idle) << NET_IDLE_BIT;
            OFF_IRQ_MASK:    rdata <= {16'h0, mask};
            OFF_PHY_MAN:     rdata <= {shift[31:18], code, shift[15:0]};
            OFF_HASH_HIGH:   rdata <= hash_high;
            OFF_HASH_LOW:    rdata <= hash_low;
            OFF_UNICAST_BASE + 8'h00: rdata <= {16'h0, sa_high[0]};
            OFF_UNICAST_BASE + 8'h04: rdata <= sa_low[0];
            OFF_UNICAST_BASE + 8'h08: rdata <= {16'h0, sa_high[1]};
            OFF_UNICAST_BASE + 8'h0c: rdata <= sa_low[1];
            OFF_UNICAST_BASE + 8'h10: rdata <= {16'h0, sa_high[2]};
            OFF_UNICAST_BASE + 8'h14: rdata <= sa_low[2];
            OFF_UNICAST_BASE + 8'h18: rdata <= {16'h0, sa_high[3]};
            OFF_UNICAST_BASE + 8'h1c: rdata <= sa_low[3];
            default:         rdata <= ZERO_RESET;
         endcase
      end else begin
         rdata <= ZERO_RESET;
      end
   end

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_enable_clears;
      req.wr && req.addr == OFF_IRQ_ENABLE |=> (mask[11:0] & $past(req.wdata[11:0])) == 12'h0;
   endproperty
   a_enable_clears: assert property (p_enable_clears)
      else $error("enable write left a mask bit set");

   property p_disable_sets;
      req.wr && req.addr == OFF_IRQ_DISABLE
         |=> (mask[11:0] & $past(req.wdata[11:0])) == $past(req.wdata[11:0]);
   endproperty
   a_disable_sets: assert property (p_disable_sets)
      else $error("disable write left a mask bit clear");

   property p_mask_upper;
      mask[15:12] == 4'hf;
   endproperty
   a_mask_upper: assert property (p_mask_upper)
      else $error("unused mask bits changed");

   property p_irq_level;
      (events & ~mask[11:0]) != 12'h0 && !(req.wr && req.addr == OFF_IRQ_DISABLE) |=> mac_irq;
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt output disagrees with status and mask");

   property p_start_busy;
      req.wr && req.addr == OFF_PHY_MAN |=> busy && mdio.mdio_oe && count == 6'h0;
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("management write did not start the shifter");

   property p_shift_sample;
      busy && mdc_rise && !(req.wr && req.addr == OFF_PHY_MAN)
         |=> shift[0] == $past(mdio_sync[1]) && mdio.mdio_out == $past(shift[30]);
   endproperty
   a_shift_sample: assert property (p_shift_sample)
      else $error("shift edge did not move the data line");

   property p_done_status;
      done_pulse && !(req.wr && req.addr == OFF_PHY_MAN) |=> status[IRQ_DONE_BIT] && !busy;
   endproperty
   a_done_status: assert property (p_done_status)
      else $error("completion did not set done status");

   property p_read_clear;
      rd_hit_status && events == 12'h0 |=> status == 12'h0;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("status read did not clear");

   property p_man_readback;
      req.rd && req.addr == OFF_PHY_MAN |=> rdata[17:16] == code && rdata[15:0] == $past(shift[15:0]);
   endproperty
   a_man_readback: assert property (p_man_readback)
      else $error("management readback wrong");

   property p_sa_high_reserved;
      req.rd && req.addr == OFF_UNICAST_BASE |=> rdata[31:16] == 16'h0;
   endproperty
   a_sa_high_reserved: assert property (p_sa_high_reserved)
      else $error("reserved unicast bits nonzero");

   property p_frame_end;
      busy && mdc_rise && count == FRAME_BITS - 6'd1 && !(req.wr && req.addr == OFF_PHY_MAN)
         |=> done_pulse && idle;
   endproperty
   a_frame_end: assert property (p_frame_end)
      else $error("frame did not end after the last shift");

   property p_write_drives;
      busy && !read_op |-> mdio.mdio_oe;
   endproperty
   a_write_drives: assert property (p_write_drives)
      else $error("write frame released the data line");

   property p_code_load;
      req.wr && req.addr == OFF_PHY_MAN |=> code == $past(req.wdata[MAN_CODE_HI:MAN_CODE_LO]);
   endproperty
   a_code_load: assert property (p_code_load)
      else $error("turnaround code not kept as written");

   property p_link_event;
      link_change |=> status[IRQ_LINK_BIT];
   endproperty
   a_link_event: assert property (p_link_event)
      else $error("link change did not set status");

   property p_hash_write;
      req.wr && req.addr == OFF_HASH_LOW |=> hash_low == $past(req.wdata);
   endproperty
   a_hash_write: assert property (p_hash_write)
      else $error("hash low write not stored");

endmodule : eth_mac_regs

// *** tb/phy_model.sv ***
// Purpose: Management-link partner: makes the link clock per frame, captures and replies
// Assumes: Frame is 32 clock periods of 80 ns, started by a pulse on start
// Notes:   Released data line floats to the pull-up level
`timescale 1ns/1ns
module phy_model (
   // Control
   input  wire logic        start,
   input  wire logic [15:0] reply,
   // Link
   input  wire logic        line,
   output logic             mdc,
   output logic             drive,
   // Observation
   output logic [31:0]      captured,
   output logic             busy
);
   initial begin
      mdc      = 1'b0;
      drive    = 1'b1;
      captured = 32'h0;
      busy     = 1'b0;
   end

   // ****************
   // Frame
   // ****************
   // Clock stands still between frames
   always @(posedge start) begin
      busy     = 1'b1;
      captured = 32'h0;
      for (int k = 1; k <= 32; k++) begin
         #40 mdc = 1'b1;
         captured = {captured[30:0], line};
         #40 mdc = 1'b0;
         // Reply changes on the falling edge, well clear of the sampling edge
         if (k >= 16 && k < 32) begin
            drive = reply[31-k];
         end else begin
            drive = 1'b1;
         end
      end
      busy = 1'b0;
   end
endmodule : phy_model

// *** tb/eth_mac_regs_bench.sv ***
// Purpose: Self-checking bench for the MAC register block
// Assumes: One-cycle register strobes, read data in the following cycle
// Notes:   Link data line resolved here from the MAC's enable, else the partner's drive value
`timescale 1ns/1ns
module eth_mac_regs_bench;
   import eth_mac_regs_pkg::*;
   logic             clk, reset, link_pin, mdio_in, mac_irq, start, busy, mdc, drive;
   reg_req_t         req;
   logic [31:0]      rdata, d, captured, v;
   logic [11:0]      irq_events;
   logic [15:0]      reply;
   mdio_io_t         mdio;
   int               errors, samples_checked, n;
   bit               give_up;

   eth_mac_regs eth_mac_regs_inst (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
      .irq_events(irq_events), .link_pin(link_pin), .mac_irq(mac_irq), .mdc(mdc),
      .mdio_in(mdio_in), .mdio(mdio));
   phy_model phy_model_inst (.start(start), .reply(reply), .line(mdio_in), .mdc(mdc),
      .drive(drive), .captured(captured), .busy(busy));

   assign mdio_in = mdio.mdio_oe ? mdio.mdio_out : drive;

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ****************
   // Tasks
   // ****************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge clk);
      req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr

   task rget(input logic [7:0] a, output logic [31:0] q);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 q = rdata;
   endtask : rget

   task rchk(input logic [7:0] a, input logic [31:0] exp);
      rget(a, d);
      chk(d, exp);
   endtask : rchk

   task frame(input logic [31:0] w);
      wr(OFF_PHY_MAN, w);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      rget(OFF_NET_STATUS, d);
      chk(32'(d[NET_IDLE_BIT]), 32'h0);
      n = 0;
      while (busy && n < 1000) begin
         @(posedge clk);
         n++;
      end
      if (busy) begin
         errors++;
         $display("FAIL %0t frame never ended", $time);
         give_up = 1'b1;
      end
      repeat (10) @(posedge clk);
   endtask : frame

   task test_done;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   // ****************
   // Sequence
   // ****************
   initial begin
      errors = 0;
      samples_checked = 0;
      reset = 1'b1;
      req = '0;
      irq_events = 12'h0;
      link_pin = 1'b0;
      start = 1'b0;
      reply = 16'hc3a5;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rchk(OFF_IRQ_MASK, 32'h0000_ffff);
      rchk(OFF_IRQ_ENABLE, 32'h0);
      rchk(OFF_IRQ_DISABLE, 32'h0);
      rchk(8'h40, 32'h0);
      for (int a = 8'h18; a <= 8'h3c; a += 4) rchk(8'(a), 32'h0);
      chk(32'(mac_irq), 32'h0);
      $display("test reset done");
      wr(OFF_IRQ_ENABLE, 32'h3);
      rchk(OFF_IRQ_MASK, 32'h0000_fffc);
      wr(OFF_IRQ_DISABLE, 32'h1);
      rchk(OFF_IRQ_MASK, 32'h0000_fffd);
      wr(OFF_IRQ_ENABLE, 32'h0);
      wr(OFF_IRQ_DISABLE, 32'h0);
      wr(OFF_IRQ_MASK, 32'h0);
      rchk(OFF_IRQ_MASK, 32'h0000_fffd);
      wr(OFF_IRQ_DISABLE, 32'hffff);
      @(posedge clk);
      irq_events <= 12'h004;
      @(posedge clk);
      irq_events <= 12'h0;
      repeat (3) @(posedge clk);
      chk(32'(mac_irq), 32'h0);
      rchk(OFF_IRQ_STATUS, 32'h4);
      $display("test masks done");
      for (int i = 1; i < IRQ_SOURCES; i++) begin
         wr(OFF_IRQ_ENABLE, 32'h1 << i);
         @(posedge clk);
         if (i == IRQ_LINK_BIT) link_pin <= ~link_pin;
         else irq_events <= 12'h1 << i;
         @(posedge clk);
         irq_events <= 12'h0;
         repeat (6) @(posedge clk);
         #1 chk(32'(mac_irq), 32'h1);
         rchk(OFF_IRQ_STATUS, 32'h1 << i);
         chk(32'(mac_irq), 32'h0);
         wr(OFF_IRQ_DISABLE, 32'h1 << i);
      end
      rchk(OFF_IRQ_MASK, 32'h0000_ffff);
      $display("test sources done");
      for (int a = 8'h18; a <= 8'h3c; a += 4) begin
         v = 32'hc3a5_0f00 | a;
         wr(8'(a), v);
         rchk(8'(a), (a >= 8'h20 && a[2] == 1'b0) ? (v & 32'hffff) : v);
      end
      $display("test filters done");
      // Reset in mid-run with the link pin high must not fake a link change
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      for (int a = 8'h18; a <= 8'h3c; a += 4) rchk(8'(a), 32'h0);
      rchk(OFF_IRQ_STATUS, 32'h0);
      rchk(OFF_IRQ_MASK, 32'h0000_ffff);
      chk(32'(mac_irq), 32'h0);
      $display("test reset again done");
      wr(OFF_IRQ_ENABLE, 32'h1);
      frame(32'h5016_beef);
      chk(captured, 32'h5016_beef);
      chk(32'(mdio.mdc_pin), 32'h0);
      #1 chk(32'(mac_irq), 32'h1);
      rchk(OFF_PHY_MAN, 32'h5016_beef);
      rget(OFF_NET_STATUS, d);
      chk(32'(d[NET_IDLE_BIT]), 32'h1);
      rchk(OFF_IRQ_STATUS, 32'h1);
      rchk(OFF_IRQ_STATUS, 32'h0);
      $display("test phy write done");
      frame(32'h6016_0000);
      chk(32'(captured[31:18]), 32'h1805);
      chk(32'(mdio.mdio_oe), 32'h0);
      rchk(OFF_PHY_MAN, 32'h6016_c3a5);
      rchk(OFF_IRQ_STATUS, 32'h1);
      $display("test phy read done");
      test_done();
   end

   // Bounded by clock count; a stuck frame cuts the run short here
   initial begin
      for (int c = 0; c < 50000 && !give_up; c++) @(posedge clk);
      errors++;
      $display("FAIL %0t run stopped early", $time);
      test_done();
   end
endmodule : eth_mac_regs_bench
